// ---- shared/asci_pkg.sv ----
package asci_pkg;

   // Timing base and conversion phase figures
   localparam int unsigned ASCI_CLK_PERIOD_PS = 10000;
   localparam int unsigned ASCI_CONV_TIME_NS  = 2200;
   localparam int unsigned ASCI_DATA_TIME_NS  = 1200;
   // Least time rounds up
   localparam int unsigned ASCI_CONV_CYC =
      (ASCI_CONV_TIME_NS * 1000 + ASCI_CLK_PERIOD_PS - 1) / ASCI_CLK_PERIOD_PS;
   // Longest time rounds down, never below one cycle
   localparam int unsigned ASCI_DATA_RAW =
      (ASCI_DATA_TIME_NS * 1000) / ASCI_CLK_PERIOD_PS;
   localparam int unsigned ASCI_DATA_CYC =
      (ASCI_DATA_RAW < 1) ? 1 : ASCI_DATA_RAW;

   // Word widths
   localparam int ASCI_CFG_W    = 14;
   localparam int ASCI_RES_W    = 16;
   localparam int ASCI_STREAM_W = ASCI_RES_W + ASCI_CFG_W + 1;
   localparam int ASCI_FCNT_W   = 5;

   // Setup word field positions
   localparam int ASCI_UPD_BIT  = 13;
   localparam int ASCI_INCC_LSB = 10;
   localparam int ASCI_REF_LSB  = 3;
   localparam int ASCI_RB_BIT   = 0;

   // Field codes
   localparam logic [2:0] ASCI_INCC_TEMP  = 3'h3;
   localparam logic       ASCI_RB_ON      = 1'h0;
   localparam logic [2:0] ASCI_REF_INT2V5 = 3'h0;
   localparam logic [2:0] ASCI_REF_INT4V1 = 3'h1;
   localparam logic [2:0] ASCI_REF_EXTB_T = 3'h2;
   localparam logic [2:0] ASCI_REF_EXT_T  = 3'h3;
   localparam logic [2:0] ASCI_REF_EXTB   = 3'h6;

   // Values after reset
   localparam logic [ASCI_CFG_W-1:0] ASCI_CFG_RST = 14'h0000;
   localparam logic [ASCI_RES_W-1:0] ASCI_RES_RST = 16'h0000;

   typedef enum logic {ASCI_ACQ, ASCI_CONV} asci_state_e;

endpackage

// ---- shared/asci_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface asci_link_if;
   import asci_pkg::*;
   logic [ASCI_CFG_W-1:0]  cfg_word;
   logic                   cfg_tgl;
   logic [ASCI_FCNT_W-1:0] fall_gray;
   modport link (output cfg_word, output cfg_tgl, output fall_gray);
   modport core (input cfg_word, input cfg_tgl, input fall_gray);
endinterface
`default_nettype wire

// ---- verilog/asci_link.sv ----
`timescale 1ns/100ps
`default_nettype none
module asci_link
   import asci_pkg::*;
(
   input  wire logic i_sck,
   input  wire logic i_resetn,
   input  wire logic i_frame_rst_n,
   input  wire logic i_sdi,
   asci_link_if.link lnk
);
   localparam int RISE_W = $clog2(ASCI_CFG_W + 1);

   logic [RISE_W-1:0]      rise_cnt_r, rise_cnt_nxt;
   logic [ASCI_CFG_W-1:0]  shift_r, shift_nxt;
   logic [ASCI_CFG_W-1:0]  word_r, word_nxt;
   logic                   tgl_r, tgl_nxt;
   logic [ASCI_FCNT_W-1:0] fall_cnt_r, fall_cnt_nxt;
   logic [ASCI_FCNT_W-1:0] fall_gray_r, fall_gray_nxt;

   always_comb begin
      rise_cnt_nxt = rise_cnt_r;
      shift_nxt    = shift_r;
      word_nxt     = word_r;
      tgl_nxt      = tgl_r;
      // Later rising edges in the same access are ignored
      if (rise_cnt_r < RISE_W'(ASCI_CFG_W)) begin
         shift_nxt    = {shift_r[ASCI_CFG_W-2:0], i_sdi};
         rise_cnt_nxt = rise_cnt_r + 1'b1;
         if (rise_cnt_r == RISE_W'(ASCI_CFG_W - 1)) begin
            word_nxt = shift_nxt;
            tgl_nxt  = ~tgl_r;
         end
      end
      // Saturates so the gray pointer never wraps inside a frame
      fall_cnt_nxt  = (fall_cnt_r == '1) ? fall_cnt_r : fall_cnt_r + 1'b1;
      fall_gray_nxt = fall_cnt_nxt ^ (fall_cnt_nxt >> 1);
   end

   // Frame counters clear while the trigger is high, as the clock stops
   always_ff @(posedge i_sck or negedge i_frame_rst_n) begin
      if (!i_frame_rst_n) begin
         rise_cnt_r <= '0;
         shift_r    <= '0;
      end else begin
         rise_cnt_r <= rise_cnt_nxt;
         shift_r    <= shift_nxt;
      end
   end

   // Word and toggle must survive the frame end for the crossing
   always_ff @(posedge i_sck or negedge i_resetn) begin
      if (!i_resetn) begin
         word_r <= ASCI_CFG_RST;
         tgl_r  <= 1'b0;
      end else begin
         word_r <= word_nxt;
         tgl_r  <= tgl_nxt;
      end
   end

   always_ff @(negedge i_sck or negedge i_frame_rst_n) begin
      if (!i_frame_rst_n) begin
         fall_cnt_r  <= '0;
         fall_gray_r <= '0;
      end else begin
         fall_cnt_r  <= fall_cnt_nxt;
         fall_gray_r <= fall_gray_nxt;
      end
   end

   assign lnk.cfg_word  = word_r;
   assign lnk.cfg_tgl   = tgl_r;
   assign lnk.fall_gray = fall_gray_r;

   word_capture_a: assert property (
      @(posedge i_sck) disable iff (!i_frame_rst_n)
      rise_cnt_r == RISE_W'(ASCI_CFG_W - 1)
      |=> (tgl_r != $past(tgl_r)) && (word_r[0] == $past(i_sdi)))
      else $error("setup word not captured on fourteenth edge");

   capture_stop_a: assert property (
      @(posedge i_sck) disable iff (!i_frame_rst_n)
      rise_cnt_r == RISE_W'(ASCI_CFG_W) |=> $stable(word_r) && $stable(tgl_r))
      else $error("setup word changed after fourteen edges");

   gray_step_a: assert property (
      @(negedge i_sck) disable iff (!i_frame_rst_n)
      fall_cnt_r != '0 |-> $countones(fall_gray_r ^ $past(fall_gray_r)) <= 1)
      else $error("falling edge pointer moved more than one bit");

endmodule
`default_nettype wire

// ---- verilog/asci_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module asci_top
   import asci_pkg::*;
#(
   parameter int unsigned CONV_CYC = ASCI_CONV_CYC,
   parameter int unsigned DATA_CYC = ASCI_DATA_CYC
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_resetn,
   input  wire logic                  i_sck,
   input  wire logic                  i_trigger,
   input  wire logic                  i_sdi,
   input  wire logic                  i_busy_mode,
   input  wire logic [ASCI_RES_W-1:0] i_sar_result,
   output logic                       o_sdo,
   output logic                       o_sdo_oen,
   output logic                       o_conv_active,
   output logic                       o_safe_window,
   output logic [ASCI_CFG_W-1:0]      o_cfg_active,
   output logic                       o_bandgap_en,
   output logic                       o_ref_4v096,
   output logic                       o_ref_buf_en,
   output logic                       o_ref_int_drive,
   output logic                       o_temp_en
);
   localparam int CNT_W  = $clog2(CONV_CYC + 1);
   localparam int CONV_D = CONV_CYC - 1;
   localparam int DATA_D = DATA_CYC;

   generate
      if (DATA_CYC < 1 || DATA_CYC >= CONV_CYC || CONV_CYC > 300) begin : g_chk
         $error("safe window must be shorter than the conversion");
      end
   endgenerate

   asci_link_if lnk ();

   logic frame_rst_n;
   // Trigger high ends the frame even when the serial clock has stopped
   assign frame_rst_n = i_resetn & ~i_trigger;

   asci_link u_link (
      .i_sck         (i_sck),
      .i_resetn      (i_resetn),
      .i_frame_rst_n (frame_rst_n),
      .i_sdi         (i_sdi),
      .lnk           (lnk)
   );

   function automatic logic [ASCI_FCNT_W-1:0] gray2bin(
      input logic [ASCI_FCNT_W-1:0] g);
      logic [ASCI_FCNT_W-1:0] b;
      b = g;
      for (int k = ASCI_FCNT_W - 2; k >= 0; k--) begin
         b[k] = b[k+1] ^ g[k];
      end
      return b;
   endfunction

   // Returns bandgap, 4.096 V select, buffer, internal drive
   function automatic logic [3:0] ref_decode(input logic [2:0] code);
      logic [3:0] r;
      case (code)
         ASCI_REF_INT2V5: r = 4'h b;
         ASCI_REF_INT4V1: r = 4'h f;
         ASCI_REF_EXTB_T: r = 4'h a;
         ASCI_REF_EXT_T:  r = 4'h 8;
         ASCI_REF_EXTB:   r = 4'h 2;
         default:         r = 4'h 0;
      endcase
      return r;
   endfunction

   function automatic logic [ASCI_RES_W-1:0] code_result(
      input logic [ASCI_RES_W-1:0] raw,
      input logic [ASCI_CFG_W-1:0] cfg);
      logic [2:0] incc;
      incc = cfg[ASCI_INCC_LSB +: 3];
      if (incc == ASCI_INCC_TEMP) begin
         code_result = raw;
      end else if (!incc[2]) begin
         code_result = {~raw[ASCI_RES_W-1], raw[ASCI_RES_W-2:0]};
      end else begin
         code_result = raw;
      end
   endfunction

   // Crossing stages: pin-like inputs, three flops, change when 2 and 3 agree
   logic [2:0]             trig_s_r, trig_s_nxt;
   logic                   trig_lvl_r, trig_lvl_nxt;
   logic [2:0]             tgl_s_r, tgl_s_nxt;
   logic                   tgl_lvl_r, tgl_lvl_nxt;
   logic [ASCI_FCNT_W-1:0] gray1_r, gray2_r, gray3_r;
   logic [ASCI_FCNT_W-1:0] idx_r, idx_nxt;

   always_comb begin
      trig_s_nxt   = {trig_s_r[1:0], i_trigger};
      trig_lvl_nxt = (trig_s_r[1] == trig_s_r[2]) ? trig_s_r[2] : trig_lvl_r;
      tgl_s_nxt    = {tgl_s_r[1:0], lnk.cfg_tgl};
      tgl_lvl_nxt  = (tgl_s_r[1] == tgl_s_r[2]) ? tgl_s_r[2] : tgl_lvl_r;
      idx_nxt      = (gray2_r == gray3_r) ? gray2bin(gray3_r) : idx_r;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         // Trigger idles high, so leaving reset gives no false rising edge
         trig_s_r   <= 3'h7;
         trig_lvl_r <= 1'b1;
         tgl_s_r    <= 3'h0;
         tgl_lvl_r  <= 1'b0;
         gray1_r    <= '0;
         gray2_r    <= '0;
         gray3_r    <= '0;
         idx_r      <= '0;
      end else begin
         trig_s_r   <= trig_s_nxt;
         trig_lvl_r <= trig_lvl_nxt;
         tgl_s_r    <= tgl_s_nxt;
         tgl_lvl_r  <= tgl_lvl_nxt;
         gray1_r    <= lnk.fall_gray;
         gray2_r    <= gray1_r;
         gray3_r    <= gray2_r;
         idx_r      <= idx_nxt;
      end
   end

   logic trig_rise, frame_start, tgl_evt, conv_end;
   assign trig_rise   = trig_lvl_nxt & ~trig_lvl_r;
   assign frame_start = trig_lvl_r & ~trig_lvl_nxt;
   assign tgl_evt     = tgl_lvl_nxt ^ tgl_lvl_r;

   asci_state_e                st_r, st_nxt;
   logic [CNT_W-1:0]           cnt_r, cnt_nxt;
   logic [ASCI_CFG_W-1:0]      cfg_r, cfg_nxt, pend_r, pend_nxt;
   logic [ASCI_CFG_W-1:0]      used_r, used_nxt;
   logic                       pend_vld_r, pend_vld_nxt;
   logic [ASCI_RES_W-1:0]      res_r, res_nxt;
   logic [ASCI_STREAM_W-1:0]   snap_r, snap_nxt, stream;
   logic [ASCI_FCNT_W-1:0]     pos;
   logic [3:0]                 refs;
   logic                       safe_r, safe_nxt, act_r, act_nxt;
   logic                       sdo_r, sdo_nxt, oen_r, oen_nxt;
   logic [3:0]                 refs_r;

   always_comb begin
      st_nxt       = st_r;
      cnt_nxt      = cnt_r;
      cfg_nxt      = cfg_r;
      pend_nxt     = pend_r;
      pend_vld_nxt = pend_vld_r;
      used_nxt     = used_r;
      res_nxt      = res_r;
      snap_nxt     = snap_r;
      conv_end     = 1'b0;
      case (st_r)
         ASCI_ACQ: begin
            if (trig_rise) begin
               st_nxt  = ASCI_CONV;
               cnt_nxt = '0;
            end
         end
         ASCI_CONV: begin
            if (cnt_r == CNT_W'(CONV_CYC - 1)) begin
               st_nxt   = ASCI_ACQ;
               conv_end = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: st_nxt = ASCI_ACQ;
      endcase
      if (conv_end) begin
         used_nxt     = cfg_r;
         res_nxt      = code_result(i_sar_result, cfg_r);
         pend_vld_nxt = 1'b0;
         // Only a word with the update bit set replaces the settings
         if (pend_vld_r && pend_r[ASCI_UPD_BIT]) begin
            cfg_nxt = pend_r;
         end
      end
      // A write landing on the conversion end stays pending: set wins
      if (tgl_evt) begin
         pend_nxt     = lnk.cfg_word;
         pend_vld_nxt = 1'b1;
      end
      stream = {res_nxt,
                (used_nxt[ASCI_RB_BIT] == ASCI_RB_ON) ? used_nxt
                                                      : {ASCI_CFG_W{1'b0}},
                1'b0};
      // Busy mode refreshes the image when the waited result arrives
      if (frame_start ||
          (conv_end && i_busy_mode && idx_r == '0 && !trig_lvl_r)) begin
         snap_nxt = stream;
      end
      pos = idx_nxt - (i_busy_mode ? 5'h01 : 5'h00);
      if (trig_lvl_nxt) begin
         sdo_nxt = 1'b0;
      end else if (i_busy_mode && idx_nxt == '0) begin
         sdo_nxt = (st_nxt == ASCI_ACQ);
      end else if (pos < 5'(ASCI_STREAM_W)) begin
         sdo_nxt = snap_nxt[5'(ASCI_STREAM_W - 1) - pos];
      end else begin
         sdo_nxt = 1'b0;
      end
      oen_nxt  = trig_lvl_nxt;
      act_nxt  = (st_nxt == ASCI_CONV);
      safe_nxt = act_nxt && (cnt_nxt < CNT_W'(DATA_CYC));
      refs     = ref_decode(cfg_nxt[ASCI_REF_LSB +: 3]);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r       <= ASCI_ACQ;
         cnt_r      <= '0;
         cfg_r      <= ASCI_CFG_RST;
         pend_r     <= ASCI_CFG_RST;
         pend_vld_r <= 1'b0;
         used_r     <= ASCI_CFG_RST;
         res_r      <= ASCI_RES_RST;
         snap_r     <= '0;
         sdo_r      <= 1'b0;
         oen_r      <= 1'b1;
         act_r      <= 1'b0;
         safe_r     <= 1'b0;
         refs_r     <= 4'h0;
      end else begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         cfg_r      <= cfg_nxt;
         pend_r     <= pend_nxt;
         pend_vld_r <= pend_vld_nxt;
         used_r     <= used_nxt;
         res_r      <= res_nxt;
         snap_r     <= snap_nxt;
         sdo_r      <= sdo_nxt;
         oen_r      <= oen_nxt;
         act_r      <= act_nxt;
         safe_r     <= safe_nxt;
         refs_r     <= refs;
      end
   end

   assign o_sdo           = sdo_r;
   assign o_sdo_oen       = oen_r;
   assign o_conv_active   = act_r;
   assign o_safe_window   = safe_r;
   assign o_cfg_active    = cfg_r;
   assign o_bandgap_en    = refs_r[3];
   assign o_ref_4v096     = refs_r[2];
   assign o_ref_buf_en    = refs_r[1];
   assign o_ref_int_drive = refs_r[0];
   // Thermometer cannot run without the bandgap, so they share one bit
   assign o_temp_en       = refs_r[3];

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   start_conv_a: assert property (
      st_r == ASCI_ACQ && trig_rise |=> o_conv_active && st_r == ASCI_CONV)
      else $error("trigger edge did not start a conversion");

   conv_length_a: assert property (
      $rose(o_conv_active) |-> ##CONV_D o_conv_active
      ##1 !o_conv_active)
      else $error("converter power not dropped at conversion end");

   safe_length_a: assert property (
      $rose(o_conv_active) |-> o_safe_window ##DATA_D !o_safe_window)
      else $error("safe access window has wrong length");

   cfg_hold_a: assert property (
      !conv_end |=> $stable(o_cfg_active))
      else $error("setup word applied outside conversion end");

   cfg_apply_a: assert property (
      conv_end && pend_vld_r && pend_r[ASCI_UPD_BIT]
      |=> o_cfg_active == $past(pend_r))
      else $error("setup word with update bit not applied");

   cfg_keep_a: assert property (
      conv_end && !(pend_vld_r && pend_r[ASCI_UPD_BIT])
      |=> o_cfg_active == $past(o_cfg_active))
      else $error("setup word without update bit changed settings");

   temp_needs_ref_a: assert property (
      o_temp_en |-> o_bandgap_en && !(o_ref_int_drive && !o_ref_buf_en))
      else $error("thermometer on without internal reference");

   ref_level_a: assert property (
      o_ref_4v096 |-> o_bandgap_en && o_ref_int_drive
      && o_cfg_active[ASCI_REF_LSB +: 3] == ASCI_REF_INT4V1)
      else $error("4.096 V selected without internal reference code");

   temp_code_a: assert property (
      conv_end && cfg_r[ASCI_INCC_LSB +: 3] == ASCI_INCC_TEMP
      |=> res_r == $past(i_sar_result))
      else $error("thermometer result not straight binary");

   sdo_release_a: assert property (
      trig_lvl_r |-> o_sdo_oen && !o_sdo)
      else $error("serial output driven while trigger high");

endmodule
`default_nettype wire

// ---- verification/asci_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module asci_host (
   input  wire logic i_sdo,
   output logic      o_sck,
   output logic      o_sdi,
   output logic      o_trigger
);
   // Serial clock stands still low outside frames
   initial begin
      o_sck     = 1'b0;
      o_sdi     = 1'b0;
      o_trigger = 1'b1;
   end

   // Device needs settling time after the fall before the first edge
   task automatic open_frame();
      o_trigger = 1'b0;
      #100;
   endtask

   // Accesses end before the trigger, so no pin moves late in a conversion
   task automatic fire();
      #30;
      o_trigger = 1'b1;
      #20;
   endtask

   // One burst of nr clocks; data is taken on each rising edge
   task automatic shift(input logic [13:0] w, input int nr,
                        output logic [30:0] got);
      got = '0;
      for (int k = 0; k < nr; k++) begin
         // Past the word the line keeps toggling, never a stale level
         o_sdi = (k < 14) ? w[13-k] : ~o_sdi;
         #62.5;
         got   = {got[29:0], i_sdo};
         o_sck = 1'b1;
         #62.5;
         o_sck = 1'b0;
      end
      #62.5;
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import asci_pkg::*;
   // Short conversion keeps the run brief
   localparam int CONV = 40;
   localparam int DATA = 20;
   logic                  i_clk;
   logic                  i_resetn;
   logic                  i_busy_mode;
   logic [ASCI_RES_W-1:0] i_sar_result;
   logic                  sck;
   logic                  sdi;
   logic                  trig;
   logic                  o_sdo;
   logic                  o_sdo_oen;
   logic                  o_conv_active;
   logic                  o_safe_window;
   logic [ASCI_CFG_W-1:0] o_cfg_active;
   logic                  o_bandgap_en;
   logic                  o_ref_4v096;
   logic                  o_ref_buf_en;
   logic                  o_ref_int_drive;
   logic                  o_temp_en;
   logic                  sdo_line;
   int                    num_errors;
   int                    n_tests;
   logic [13:0]           cur_cfg;
   logic [13:0]           res_cfg;
   logic [15:0]           res_exp;

   always #5 i_clk = ~i_clk;

   asci_top #(.CONV_CYC(CONV), .DATA_CYC(DATA)) dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_sck(sck), .i_trigger(trig),
      .i_sdi(sdi), .i_busy_mode(i_busy_mode), .i_sar_result(i_sar_result),
      .o_sdo(o_sdo), .o_sdo_oen(o_sdo_oen), .o_conv_active(o_conv_active),
      .o_safe_window(o_safe_window), .o_cfg_active(o_cfg_active),
      .o_bandgap_en(o_bandgap_en), .o_ref_4v096(o_ref_4v096),
      .o_ref_buf_en(o_ref_buf_en), .o_ref_int_drive(o_ref_int_drive),
      .o_temp_en(o_temp_en));

   // Released output has no pull, so the host sees the inverse of the level
   assign sdo_line = o_sdo_oen ? ~o_sdo : o_sdo;

   asci_host host (.i_sdo(sdo_line), .o_sck(sck), .o_sdi(sdi),
                   .o_trigger(trig));

   task automatic give_verdict();
      $display("errors %0d, comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   task automatic hang();
      num_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      give_verdict();
   endtask

   function automatic logic [2:0] ref_exp(input logic [2:0] c);
      case (c)
         3'h0, 3'h1: return 3'h7;
         3'h2:       return 3'h6;
         3'h3:       return 3'h4;
         3'h6:       return 3'h2;
         default:    return 3'h0;
      endcase
   endfunction

   // Model of one conversion: result coded by the word then in force
   task automatic conv_model(input logic [15:0] sar, input logic [13:0] w);
      res_exp = sar;
      if (!cur_cfg[12] && cur_cfg[12:10] != ASCI_INCC_TEMP)
         res_exp[15] = ~sar[15];
      res_cfg = cur_cfg;
      if (w[ASCI_UPD_BIT])
         cur_cfg = w;
   endtask

   task automatic wait_end(output int act, output int safe);
      int n;
      n    = 0;
      act  = 0;
      safe = 0;
      while (o_conv_active !== 1'b1) begin
         @(posedge i_clk);
         #1;
         n++;
         if (n > 300) hang();
      end
      while (o_conv_active === 1'b1) begin
         act++;
         if (o_safe_window === 1'b1) safe++;
         @(posedge i_clk);
         #1;
         if (act > 300) hang();
      end
   endtask

   // Frame with readout and write, then one conversion
   task automatic step(input logic [13:0] w, input logic chk,
                       input logic [15:0] sar);
      logic [30:0] got;
      logic [13:0] echo;
      logic [2:0]  r;
      logic [2:0]  rs;
      logic [31:0] xs;
      int          act;
      int          safe;
      host.open_frame();
      host.shift(w, 30 + int'(i_busy_mode), got);
      echo = (res_cfg[ASCI_RB_BIT] == ASCI_RB_ON) ? res_cfg : 14'h0000;
      xs   = {1'b0, i_busy_mode, res_exp, echo};
      if (chk) check(32'(got), xs, "stream");
      check(32'(o_cfg_active), 32'(cur_cfg), "cfg early");
      @(posedge i_clk);
      i_sar_result <= sar;
      host.fire();
      wait_end(act, safe);
      check(32'(act), 32'(CONV), "conv len");
      check(32'(safe), 32'(DATA), "safe len");
      conv_model(sar, w);
      r  = ref_exp(cur_cfg[5:3]);
      rs = {o_bandgap_en, o_ref_buf_en, o_ref_int_drive};
      check(32'(o_cfg_active), 32'(cur_cfg), "cfg");
      check(32'(rs), 32'(r), "ref");
      check({31'h0, o_temp_en}, {31'h0, r[2]}, "temp");
      check(32'(o_ref_4v096), 32'(cur_cfg[5:3] == 3'h1), "4v");
   endtask

   task automatic t_reset();
      check({30'h0, o_sdo_oen, o_conv_active}, 32'h2, "idle");
      check({18'h0, o_cfg_active}, {18'h0, ASCI_CFG_RST}, "cfg rst");
      step({1'b1, 3'h7, 10'h3c0}, 1'b0, 16'h4321);
   endtask

   // Every reference code, thermometer and bipolar channels, readback toggled
   task automatic t_refs();
      logic [2:0] codes [6];
      logic [2:0] incs [3];
      codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
      incs  = '{3'h3, 3'h7, 3'h2};
      for (int i = 0; i < 7; i++)
         step({1'b1, incs[i%3], 3'h5, 1'b0, codes[i%6], 2'h0, 1'(i)},
              1'b1, 16'h9a5c + 16'(i) * 16'h1111);
   endtask

   task automatic t_keep();
      step({1'b0, 13'h1abc}, 1'b1, 16'h7ff1);
      step({1'b0, 13'h0000}, 1'b1, 16'h0001);
   endtask

   // Busy bit reads 0 in conversion, then 1 once the result is in
   task automatic t_busy();
      int act;
      int safe;
      @(posedge i_clk);
      i_busy_mode <= 1'b1;
      host.open_frame();
      @(posedge i_clk);
      i_sar_result <= 16'hc0de;
      host.fire();
      #100;
      host.open_frame();
      check({30'h0, o_sdo_oen, o_sdo}, 32'h0, "busy low");
      wait_end(act, safe);
      repeat (3) @(posedge i_clk);
      #1;
      check({31'h0, o_sdo}, 32'h1, "busy high");
      conv_model(16'hc0de, 14'h0000);
      step(14'h0000, 1'b1, 16'h5a5a);
      @(posedge i_clk);
      i_busy_mode <= 1'b0;
   endtask

   task automatic t_default();
      step(14'h3fff, 1'b1, 16'h8000);
      step(14'h3fff, 1'b1, 16'hffff);
      step(14'h0000, 1'b1, 16'h0000);
   endtask

   initial begin
      i_clk        = 1'b0;
      i_resetn     = 1'b0;
      i_busy_mode  = 1'b0;
      i_sar_result = '0;
      num_errors   = 0;
      n_tests      = 0;
      cur_cfg      = ASCI_CFG_RST;
      res_cfg      = ASCI_CFG_RST;
      res_exp      = ASCI_RES_RST;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      #1;
      t_reset();
      t_refs();
      t_keep();
      t_busy();
      t_default();
      give_verdict();
   end
endmodule
`default_nettype wire
